// ===== sto_monitor.sv
// Dual-channel torque-off monitor top: filters, timer, fault latch
// Functional notes
// - Both inputs low: safe state, block start and power, status on.
// - Both inputs high: run permitted under software, status off.
// - Inputs differ: block start, status off, even without fault.
// - Disagreement under 1.6 s never faults; nominal detection 2.3 s.
// - Disagreement over 3.0 s always becomes a fault.
// - Only opposite channel levels count toward fault detection.
// - Timeout moves into latched fault with no further input change.
// - Latched fault blocks start and holds status off always.
// - Only a full power cycle leaves the fault; no input clears it.
// - Low pulses under 2 ms on either input are ignored.
// - React to a low input only after about 6 ms low.
// - Trip history logged only when running or starting, never idle.
`default_nettype none
module sto_monitor #(
    parameter int unsigned REACT_CYC    = sto_pkg::REACT_CYC,
    parameter int unsigned MISMATCH_CYC = sto_pkg::MISMATCH_CYC
) (
    // Clock and power-on reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Safety channels from the external controller
    input  wire logic safety_input_a_i,
    input  wire logic safety_input_b_i,
    // Drive activity
    input  wire logic drive_running_i,
    input  wire logic start_req_i,
    // Permission and indication
    output logic      run_permit_o,
    output logic      status_output_pos_o,
    output logic      status_output_neg_o,
    output logic      fault_o,
    output logic      trip_o,
    output logic      trip_log_o
);
    import sto_pkg::*;

    localparam int unsigned TW = $clog2(MISMATCH_CYC + 1);

    logic          lvl_a;
    logic          lvl_b;
    sto_state_e    state_q;
    sto_state_e    state_d;
    logic [TW-1:0] mis_cnt_q;
    logic [TW-1:0] mis_cnt_d;
    logic          trip_q;
    logic          trip_d;
    logic          permit_q;
    logic          status_q;
    logic          log_q;

    sto_chan_filter #(.REACT_CYC(REACT_CYC)) u_filt_a (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .raw_i     (safety_input_a_i),
        .level_o   (lvl_a)
    );

    sto_chan_filter #(.REACT_CYC(REACT_CYC)) u_filt_b (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .raw_i     (safety_input_b_i),
        .level_o   (lvl_b)
    );

    wire both_low  = !lvl_a && !lvl_b;
    wire both_high = lvl_a && lvl_b;
    wire mismatch  = lvl_a ^ lvl_b;
    wire timeout   = (mis_cnt_q >= TW'(MISMATCH_CYC - 1));
    wire active    = drive_running_i || start_req_i;

    // Timer clears on agreement and once fault is latched; it holds at timeout
    assign mis_cnt_d = (!mismatch || state_q == STO_FAULT) ? '0
                     : (timeout ? mis_cnt_q : mis_cnt_q + 1'b1);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            STO_FAULT: state_d = STO_FAULT;
            default: begin
                if (mismatch && timeout) begin
                    state_d = STO_FAULT;
                end else if (mismatch) begin
                    state_d = STO_MISMATCH;
                end else if (both_high) begin
                    state_d = STO_RUN;
                end else begin
                    state_d = STO_SAFE;
                end
            end
        endcase
    end

    // Any non-run state trips an active drive
    assign trip_d = (state_d != STO_RUN) && active;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q   <= STO_SAFE;
            mis_cnt_q <= '0;
            trip_q    <= 1'b0;
            permit_q  <= 1'b0;
            status_q  <= 1'b0;
            log_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            mis_cnt_q <= mis_cnt_d;
            trip_q    <= trip_d;
            permit_q  <= (state_d == STO_RUN);
            status_q  <= (state_d == STO_SAFE);
            // History entry only on the rising edge of an active trip
            log_q     <= trip_d && !trip_q;
        end
    end

    // Status output modelled as an isolated switch pair
    assign status_output_pos_o = status_q;
    assign status_output_neg_o = !status_q;
    assign run_permit_o        = permit_q;
    assign fault_o             = (state_q == STO_FAULT);
    assign trip_o              = trip_q;
    assign trip_log_o          = log_q;

    // Helper: cycles of continuous disagreement
    logic [TW:0] hold_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hold_q <= '0;
        end else if (mismatch && hold_q <= TW'(MISMATCH_CYC)) begin
            hold_q <= hold_q + 1'b1;
        end else if (!mismatch) begin
            hold_q <= '0;
        end
    end

    property p_safe_status;
        @(posedge sys_clk_i) disable iff (rst_i)
        (both_low && state_q != STO_FAULT) |=> status_q && !permit_q;
    endproperty
    a_safe_status: assert property (p_safe_status)
        else $error("both low did not give safe status");

    property p_run_permit;
        @(posedge sys_clk_i) disable iff (rst_i)
        (both_high && state_q != STO_FAULT) |=> permit_q && !status_q;
    endproperty
    a_run_permit: assert property (p_run_permit)
        else $error("both high did not permit run");

    property p_mismatch_block;
        @(posedge sys_clk_i) disable iff (rst_i)
        mismatch |=> !permit_q && !status_q;
    endproperty
    a_mismatch_block: assert property (p_mismatch_block)
        else $error("disagreement did not block start");

    property p_no_early_fault;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(fault_o) |-> hold_q >= (TW+1)'(MISMATCH_CYC);
    endproperty
    a_no_early_fault: assert property (p_no_early_fault)
        else $error("fault before detection time");

    property p_fault_in_time;
        @(posedge sys_clk_i) disable iff (rst_i)
        (mismatch && timeout) |=> fault_o;
    endproperty
    a_fault_in_time: assert property (p_fault_in_time)
        else $error("timeout did not latch fault");

    property p_fault_sticky;
        @(posedge sys_clk_i) disable iff (rst_i)
        fault_o |=> fault_o && !permit_q && !status_q;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault latch released");

    property p_trip_active;
        @(posedge sys_clk_i) disable iff (rst_i)
        (active && (!both_high || fault_o)) |=> trip_q;
    endproperty
    a_trip_active: assert property (p_trip_active)
        else $error("trip missing while active");

    property p_log_needs_active;
        @(posedge sys_clk_i) disable iff (rst_i)
        log_q |-> $past(active);
    endproperty
    a_log_needs_active: assert property (p_log_needs_active)
        else $error("trip logged while idle");

    c_fault: cover property (@(posedge sys_clk_i) $rose(fault_o));
    c_run: cover property (@(posedge sys_clk_i) $rose(permit_q));
    c_log: cover property (@(posedge sys_clk_i) log_q);
endmodule
`default_nettype wire

// ===== sto_pkg.sv
// Package for the dual-channel torque-off monitor: timing and states
`default_nettype none
package sto_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    // Low-going immunity and reaction times, in microseconds
    localparam int unsigned IMMUNE_US     = 2_000;
    localparam int unsigned REACT_US      = 6_000;
    // Disagreement detection time, in milliseconds
    localparam int unsigned MISMATCH_MS   = 2_300;
    localparam int unsigned MISMATCH_MIN_MS = 1_600;
    localparam int unsigned MISMATCH_MAX_MS = 3_000;
    localparam int unsigned REACT_CYC     =
        (REACT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned MISMATCH_CYC  =
        (MISMATCH_MS * (CLK_HZ / 1_000));
    localparam logic [1:0] RST_SYNC       = 2'h0;

    typedef enum logic [1:0] {
        STO_SAFE     = 2'h0,
        STO_MISMATCH = 2'h1,
        STO_RUN      = 2'h3,
        STO_FAULT    = 2'h2
    } sto_state_e;
endpackage
`default_nettype wire

// ===== sto_chan_filter.sv
// Per-channel synchroniser and low-going pulse filter
`default_nettype none
module sto_chan_filter #(
    parameter int unsigned REACT_CYC = 60000
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Raw safety input and filtered level
    input  wire logic raw_i,
    output logic      level_o
);
    import sto_pkg::*;

    localparam int unsigned CW = $clog2(REACT_CYC + 1);

    logic [1:0]    sync_q;
    logic [CW-1:0] low_cnt_q;
    logic [CW-1:0] low_cnt_d;
    logic          level_q;
    logic          level_d;
    wire           in_s = sync_q[1];
    wire           expired = (low_cnt_q >= CW'(REACT_CYC - 1));

    // Low held long enough drops the level; any high restores it
    assign low_cnt_d = in_s ? '0 : (expired ? low_cnt_q : low_cnt_q + 1'b1);
    assign level_d   = in_s ? 1'b1 : (expired ? 1'b0 : level_q);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            // Resets low: power-up never grants a false run permit
            sync_q    <= RST_SYNC;
            low_cnt_q <= '0;
            level_q   <= 1'b0;
        end else begin
            sync_q    <= {sync_q[0], raw_i};
            low_cnt_q <= low_cnt_d;
            level_q   <= level_d;
        end
    end

    assign level_o = level_q;

    // Level may only fall after the full reaction time of low input
    property p_no_early_drop;
        @(posedge sys_clk_i) disable iff (rst_i)
        $fell(level_q) |-> $past(low_cnt_q) >= CW'(REACT_CYC - 1);
    endproperty
    a_no_early_drop: assert property (p_no_early_drop)
        else $error("level fell before reaction time");

    property p_high_restores;
        @(posedge sys_clk_i) disable iff (rst_i)
        in_s |=> level_q;
    endproperty
    a_high_restores: assert property (p_high_restores)
        else $error("high input did not restore level");
endmodule
`default_nettype wire

// ===== sto_relay_model.sv
// Safety relay model driving both torque-off channels
`default_nettype none
module sto_relay_model (
    // Clock
    input  wire logic sys_clk_i,
    // Channel levels
    output logic      chan_a_o,
    output logic      chan_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        chan_a_o = 1'b0;
        chan_b_o = 1'b0;
    end
    // Both contacts switch on one edge
    task automatic set_both(input logic lvl);
        @(posedge sys_clk_i);
        chan_a_o <= lvl;
        chan_b_o <= lvl;
    endtask
    // Independent levels: skew, or a stuck channel on command
    task automatic set_pair(input logic a, input logic b);
        @(posedge sys_clk_i);
        chan_a_o <= a;
        chan_b_o <= b;
    endtask
    // Width is kept under the immunity width by the caller
    task automatic pulse_low(input logic sel_b, input int unsigned width);
        @(posedge sys_clk_i);
        if (sel_b) chan_b_o <= 1'b0;
        else chan_a_o <= 1'b0;
        repeat (width) @(posedge sys_clk_i);
        chan_a_o <= 1'b1;
        chan_b_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== sto_monitor_bench.sv
// Self-checking bench for the dual-channel torque-off monitor
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin \
    fail_count++; $display("unexpected at %0t: got %h expected %h", \
    $time, act, exp); end end
module sto_monitor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned REACT = 20;
    localparam int unsigned MISM  = 100;
    logic sys_clk = 1'b0;
    // Test pulse width scaled to stay under the immunity width
    localparam int unsigned PULSE =
        REACT * sto_pkg::IMMUNE_US / sto_pkg::REACT_US;
    logic rst;
    logic running;
    logic start;
    wire logic ch_a, ch_b, permit, st_pos, st_neg, fault, trip, trip_log;
    int   fail_count  = 0;
    int   comparisons = 0;
    int   log_cnt     = 0;
    always #50 sys_clk = ~sys_clk;
    // Trip history entries seen so far
    always @(posedge sys_clk) if (trip_log === 1'b1) log_cnt++;
    sto_relay_model relay (.sys_clk_i(sys_clk), .chan_a_o(ch_a),
                           .chan_b_o(ch_b));
    sto_monitor #(.REACT_CYC(REACT), .MISMATCH_CYC(MISM)) uut (
        .sys_clk_i(sys_clk), .rst_i(rst), .safety_input_a_i(ch_a),
        .safety_input_b_i(ch_b), .drive_running_i(running),
        .start_req_i(start), .run_permit_o(permit),
        .status_output_pos_o(st_pos), .status_output_neg_o(st_neg),
        .fault_o(fault), .trip_o(trip), .trip_log_o(trip_log));
    // Sample well after the edge so its updates have landed
    task automatic wait_cyc(input int unsigned n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    // Control levels change on a rising edge only
    task automatic set_ctl(input logic run, input logic req);
        @(posedge sys_clk);
        running <= run;
        start   <= req;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    task automatic t_safe();
        relay.set_both(1'b0);
        wait_cyc(150);
        `CHK(st_pos, 1'b1)
        `CHK(st_neg, 1'b0)
        `CHK(permit, 1'b0)
        `CHK(fault, 1'b0)
    endtask
    task automatic t_run();
        relay.set_both(1'b1);
        wait_cyc(10);
        `CHK(permit, 1'b1)
        `CHK(st_pos, 1'b0)
    endtask
    // Test pulses while running must leave no trace
    task automatic t_pulse();
        set_ctl(1'b1, 1'b0);
        relay.pulse_low(1'b0, PULSE);
        relay.pulse_low(1'b1, PULSE);
        wait_cyc(30);
        `CHK(permit, 1'b1)
        `CHK(trip, 1'b0)
        `CHK(log_cnt, 0)
    endtask
    // Two short mismatches back to back; a timer that kept
    // counting across them would reach the fault
    task automatic t_react();
        relay.set_pair(1'b0, 1'b1);
        wait_cyc(REACT - 4);
        `CHK(permit, 1'b1)
        wait_cyc(64);
        `CHK(permit, 1'b0)
        `CHK(st_pos, 1'b0)
        `CHK(trip, 1'b1)
        `CHK(log_cnt, 1)
        relay.set_pair(1'b1, 1'b0);
        wait_cyc(REACT + 60);
        relay.set_both(1'b1);
        wait_cyc(10);
        `CHK(fault, 1'b0)
        `CHK(permit, 1'b1)
        `CHK(log_cnt, 2)
        set_ctl(1'b0, 1'b0);
    endtask
    task automatic t_idle();
        relay.set_both(1'b0);
        wait_cyc(REACT + 10);
        `CHK(trip, 1'b0)
        `CHK(log_cnt, 2)
        set_ctl(1'b0, 1'b1);
        wait_cyc(5);
        `CHK(trip, 1'b1)
        `CHK(log_cnt, 3)
        set_ctl(1'b0, 1'b0);
    endtask
    task automatic t_fault();
        int unsigned n;
        relay.set_both(1'b1);
        wait_cyc(10);
        relay.set_pair(1'b1, 1'b0);
        wait_cyc(REACT + 65);
        `CHK(fault, 1'b0)
        n = 0;
        while (fault !== 1'b1 && n < 75) begin
            wait_cyc(1);
            n++;
        end
        `CHK(fault, 1'b1)
        relay.set_both(1'b1);
        wait_cyc(30);
        `CHK(fault, 1'b1)
        `CHK(permit, 1'b0)
        relay.set_both(1'b0);
        wait_cyc(REACT + 20);
        `CHK(st_pos, 1'b0)
        `CHK(fault, 1'b1)
        do_reset();
        wait_cyc(REACT + 20);
        `CHK(fault, 1'b0)
        `CHK(st_pos, 1'b1)
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        rst     <= 1'b1;
        running <= 1'b0;
        start   <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_safe();
        t_run();
        t_pulse();
        t_react();
        t_idle();
        t_fault();
        give_verdict();
    end
    // Whole run needs about 670 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
